/* src/slcg_regs.vh */
`ifndef SLCG_REGS_VH
`define SLCG_REGS_VH
// ---------------------------------------------------------------
// register numbers and reset values
// ---------------------------------------------------------------
`define SLCG_REG_TABLE      8'h08
`define SLCG_REG_IDENT      8'hF0
`define SLCG_REG_SETADDR    8'hFE
`define SLCG_TABLE_LAST     5'h1F
`define SLCG_IDENT_LAST     3'h5
`define SLCG_TARGET_RST     7'h20
`define SLCG_ADDR_BCAST     8'hFF
`define SLCG_ADDR_LIMIT     8'h80
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SLCG_SCENE_HI       7
`define SLCG_SCENE_LO       4
`define SLCG_SEL_HI         2
`define SLCG_SEL_LO         0
`define SLCG_ADDR_SBIT      0
// ---------------------------------------------------------------
// function selectors
// ---------------------------------------------------------------
`define SLCG_SEL_TWO_DIM    3'h0
`define SLCG_SEL_TWO_ONOFF  3'h1
`define SLCG_SEL_DIM        3'h2
`define SLCG_SEL_ONOFF      3'h3
`define SLCG_SEL_SCENE      3'h4
`define SLCG_SEL_STEP       3'h5
`define SLCG_SEL_LOCK       3'h6
// ---------------------------------------------------------------
// lighting bus command codes
// ---------------------------------------------------------------
`define SLCG_CMD_OFF        8'h00
`define SLCG_CMD_UP         8'h01
`define SLCG_CMD_DOWN       8'h02
`define SLCG_CMD_MAX        8'h05
`define SLCG_CMD_SCENE      4'h1
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SLCG_CLK_NS         100
`define SLCG_TICK_NS        1000000
`define SLCG_DEBOUNCE_MS    10'd20
`define SLCG_HOLD_MS        10'd400
`define SLCG_REPEAT_MS      10'd200
`endif

/* src/slcg_switch_cmd_gen.v */
// Operation
// - mode byte: scene number high nibble, bit 3 reserved, selector in bits 2..0
// - selectors 0..6 pick two-switch dim/onoff, dim, onoff, scene, step, locking
// - two-switch functions live on even inputs, paired with the next odd input
// - paired odd input's selector bits are ignored under a two-switch function
// - all functions use momentary contacts except selector 6, which latches
// - two-switch dim: short even press gives max, short odd press gives off
// - two-switch dim: held even dims up, held odd dims down while held
// - two-switch on/off: even gives max, odd gives off, holding never dims
// - single dimming: brief press toggles between off and max
// - single dimming hold: up if off, down if on, then alternate
// - single on/off: each press toggles max and off, hold adds nothing
// - go-to-scene: press recalls the scene held in the mode byte
// - scene stepping: each closure recalls counter 0..scene then wraps
// - locking switch: max on closing, off on opening
// - address byte selects lamp, group or broadcast like the command address
// - paired odd input's address byte is ignored under a two-switch function
// - address bit 0 clear: closing sends address then raw mode byte as power
// - identification returns six fixed bytes: maker, product, version, high first
// - maker and product codes are sixteen bits each
// - version is four BCD digits, most significant in top nibble
// - target address change needs address then its complement, checked
// - address change with first byte 128 or more is rejected
// - address byte: bit 7 group select, bits 6..1 address, bit 0 power/command
// - table: even modes 0-7, even addresses 8-15, odd modes 16-23, odd 24-31
// - first written byte picks the register; reads follow a repeated start
`timescale 1ns/1ns
`default_nettype none
`include "slcg_regs.vh"
module slcg_switch_cmd_gen #(
    parameter TICK_CYCLES = `SLCG_TICK_NS / `SLCG_CLK_NS,
    parameter [15:0] MAKER_CODE   = 16'h5A5A, // arbitrary value
    parameter [15:0] PRODUCT_CODE = 16'h00A7, // arbitrary value
    parameter [15:0] VERSION_BCD  = 16'h1000
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [15:0] switch_input_pin_n,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_q,
    output reg         sda_oe_q,
    output reg         cmd_valid_q,
    input  wire        cmd_ready,
    output reg  [7:0]  cmd_addr_q,
    output reg  [7:0]  cmd_data_q
);
// ---------------------------------------------------------------
// i2c states
// ---------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'd0, ST_DEV = 3'd1, ST_DACK = 3'd2, ST_RX = 3'd3,
                 ST_RXACK = 3'd4, ST_TX = 3'd5, ST_TXACK = 3'd6;
reg  [7:0]  tbl_q [0:31];
reg  [2:0]  st_q;
reg  [3:0]  bit_q;
reg  [7:0]  sr_q, tx_q, reg_q;
reg  [4:0]  idx_q;
reg         first_q, nack_q;
reg  [6:0]  target_q;
reg  [7:0]  sa_first_q;
reg         scl_q, sda_q;
reg  [7:0]  rd_byte;
wire        scl_rise = ~scl_q & scl_in;
wire        scl_fall = scl_q & ~scl_in;
wire        start_c  = scl_in & scl_q & sda_q & ~sda_in;
wire        stop_c   = scl_in & scl_q & ~sda_q & sda_in;
wire [7:0]  rx_byte  = sr_q;
wire [47:0] ident_w  = {MAKER_CODE, PRODUCT_CODE, VERSION_BCD};
integer     k;
function [7:0] def_addr;
    input [2:0] pair;
    begin
        def_addr = (pair == 3'd0) ? `SLCG_ADDR_BCAST : {4'h0, pair - 3'd1, 1'b1};
    end
endfunction
// ---------------------------------------------------------------
// read data, i2c target and register file
// ---------------------------------------------------------------
always @* begin
    rd_byte = 8'h00;
    if (reg_q == `SLCG_REG_TABLE)
        rd_byte = tbl_q[idx_q];
    else if (reg_q == `SLCG_REG_IDENT && idx_q[2:0] <= `SLCG_IDENT_LAST)
        rd_byte = ident_w[8'd47 - {2'b00, idx_q[2:0], 3'b000} -: 8];
end
always @(posedge clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    sda_out_q <= 1'b0;
    if (srst) begin
        st_q <= ST_IDLE;
        reg_q <= 8'h00;
        idx_q <= 5'h00;
        target_q <= `SLCG_TARGET_RST;
        sda_oe_q <= 1'b0;
        for (k = 0; k < 8; k = k + 1) begin
            tbl_q[k] <= {5'h00, `SLCG_SEL_TWO_DIM};
            tbl_q[k + 8] <= def_addr(k[2:0]);
            tbl_q[k + 16] <= {5'h00, `SLCG_SEL_TWO_DIM};
            tbl_q[k + 24] <= def_addr(k[2:0]);
        end
    end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        reg_q <= 8'h00;
        idx_q <= 5'h00;
    end else if (start_c) begin
        st_q <= ST_DEV;
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
    end else begin
        case (st_q)
            ST_DEV, ST_RX: begin
                if (scl_rise) begin
                    sr_q <= {sr_q[6:0], sda_in};
                    bit_q <= bit_q + 4'h1;
                end else if (scl_fall && bit_q == 4'h8) begin
                    if (st_q == ST_DEV) begin
                        if (rx_byte[7:1] == target_q) begin
                            sda_oe_q <= 1'b1;
                            st_q <= ST_DACK;
                        end else
                            st_q <= ST_IDLE;
                    end else begin
                        sda_oe_q <= 1'b1;
                        st_q <= ST_RXACK;
                        first_q <= 1'b0;
                        idx_q <= idx_q + 5'h01;
                        if (first_q) begin
                            reg_q <= rx_byte;
                            idx_q <= 5'h00;
                        end else if (reg_q == `SLCG_REG_TABLE)
                            tbl_q[idx_q] <= rx_byte;
                        else if (reg_q == `SLCG_REG_SETADDR) begin
                            if (idx_q == 5'h00)
                                sa_first_q <= rx_byte;
                            else if (idx_q == 5'h01 && sa_first_q < `SLCG_ADDR_LIMIT
                                     && rx_byte == ~sa_first_q)
                                target_q <= sa_first_q[6:0];
                        end
                    end
                end
            end
            ST_DACK: begin
                if (scl_fall) begin
                    bit_q <= 4'h0;
                    if (sr_q[0]) begin
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe_q <= ~rd_byte[7];
                        bit_q <= 4'h1;
                        st_q <= ST_TX;
                    end else begin
                        sda_oe_q <= 1'b0;
                        first_q <= 1'b1;
                        st_q <= ST_RX;
                    end
                end
            end
            ST_RXACK: begin
                if (scl_fall) begin
                    sda_oe_q <= 1'b0;
                    bit_q <= 4'h0;
                    st_q <= ST_RX;
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    if (bit_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        st_q <= ST_TXACK;
                        idx_q <= (reg_q == `SLCG_REG_IDENT && idx_q[2:0] == `SLCG_IDENT_LAST)
                                 ? 5'h00 : idx_q + 5'h01;
                    end else begin
                        sda_oe_q <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end
                end
            end
            ST_TXACK: begin
                if (scl_rise)
                    nack_q <= sda_in;
                else if (scl_fall) begin
                    if (nack_q)
                        st_q <= ST_IDLE;
                    else begin
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe_q <= ~rd_byte[7];
                        bit_q <= 4'h1;
                        st_q <= ST_TX;
                    end
                end
            end
            default: st_q <= ST_IDLE;
        endcase
    end
end
// ---------------------------------------------------------------
// switch debounce, event flags and decode
// ---------------------------------------------------------------
reg  [31:0] tick_cnt_q;
reg         tick_q;
reg  [15:0] stable_q;
reg  [15:0] held_q;
reg  [15:0] ev_press_q, ev_rel_q, ev_hold_q, ev_rep_q;
reg  [15:0] lamp_q, dirup_q, fresh_q;
reg  [4:0]  deb_q  [0:15];
reg  [9:0]  hold_q [0:15];
reg  [3:0]  step_q [0:15];
reg  [3:0]  scan_q;
integer     i;
wire [2:0]  pair     = scan_q[3:1];
wire        odd      = scan_q[0];
wire        two      = tbl_q[{2'b00, pair}][`SLCG_SEL_HI:1] == 2'b00;
wire        use_pair = odd & two;
wire [7:0]  mode_b   = use_pair ? tbl_q[{2'b00, pair}] : tbl_q[{odd, 1'b0, pair}];
wire [7:0]  addr_b   = use_pair ? tbl_q[{2'b01, pair}] : tbl_q[{odd, 1'b1, pair}];
wire [2:0]  sel      = mode_b[`SLCG_SEL_HI:`SLCG_SEL_LO];
wire [3:0]  scene    = mode_b[`SLCG_SCENE_HI:`SLCG_SCENE_LO];
wire        e_press  = ev_press_q[scan_q];
wire        e_hold   = ~e_press & ev_hold_q[scan_q];
wire        e_rep    = ~e_press & ~e_hold & ev_rep_q[scan_q];
wire        e_rel    = ~e_press & ~e_hold & ~e_rep & ev_rel_q[scan_q];
wire        lamp     = lamp_q[scan_q];
wire        up_now   = fresh_q[scan_q] ? ~lamp : ~dirup_q[scan_q];
wire        issue_ok = ~cmd_valid_q | cmd_ready;
reg         go;
reg  [7:0]  dbyte;
always @* begin
    go = 1'b0;
    dbyte = `SLCG_CMD_OFF;
    if (~addr_b[`SLCG_ADDR_SBIT]) begin
        go = e_press;
        dbyte = mode_b;
    end else begin
        case (sel)
            `SLCG_SEL_TWO_DIM: begin
                if (~odd | use_pair) begin
                    go = e_hold | e_rep | (e_rel & ~held_q[scan_q]);
                    if (e_rel)
                        dbyte = odd ? `SLCG_CMD_OFF : `SLCG_CMD_MAX;
                    else
                        dbyte = odd ? `SLCG_CMD_DOWN : `SLCG_CMD_UP;
                end
            end
            `SLCG_SEL_TWO_ONOFF: begin
                go = e_press & (~odd | use_pair);
                dbyte = odd ? `SLCG_CMD_OFF : `SLCG_CMD_MAX;
            end
            `SLCG_SEL_DIM: begin
                go = e_hold | e_rep | (e_rel & ~held_q[scan_q]);
                if (e_rel)
                    dbyte = lamp ? `SLCG_CMD_OFF : `SLCG_CMD_MAX;
                else if (e_hold)
                    dbyte = up_now ? `SLCG_CMD_UP : `SLCG_CMD_DOWN;
                else
                    dbyte = dirup_q[scan_q] ? `SLCG_CMD_UP : `SLCG_CMD_DOWN;
            end
            `SLCG_SEL_ONOFF: begin
                go = e_press;
                dbyte = lamp ? `SLCG_CMD_OFF : `SLCG_CMD_MAX;
            end
            `SLCG_SEL_SCENE, `SLCG_SEL_STEP: begin
                go = e_press;
                dbyte = {`SLCG_CMD_SCENE, sel[0] ? step_q[scan_q] : scene};
            end
            `SLCG_SEL_LOCK: begin
                go = e_press | e_rel;
                dbyte = e_press ? `SLCG_CMD_MAX : `SLCG_CMD_OFF;
            end
            default: go = 1'b0;
        endcase
    end
end
// ---------------------------------------------------------------
// debounce, scanning and command issue
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (srst) begin
        tick_cnt_q <= 32'h0;
        tick_q <= 1'b0;
        stable_q <= 16'h0000;
        held_q <= 16'h0000;
        ev_press_q <= 16'h0000;
        ev_rel_q <= 16'h0000;
        ev_hold_q <= 16'h0000;
        ev_rep_q <= 16'h0000;
        lamp_q <= 16'h0000;
        dirup_q <= 16'h0000;
        fresh_q <= 16'hFFFF;
        scan_q <= 4'h0;
        cmd_valid_q <= 1'b0;
        cmd_addr_q <= 8'h00;
        cmd_data_q <= 8'h00;
        for (i = 0; i < 16; i = i + 1) begin
            deb_q[i] <= 5'h00;
            hold_q[i] <= 10'h000;
            step_q[i] <= 4'h0;
        end
    end else begin
        tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
        tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0 : tick_cnt_q + 32'h1;
        if (cmd_ready)
            cmd_valid_q <= 1'b0;
        if (issue_ok) begin
            scan_q <= scan_q + 4'h1;
            ev_press_q[scan_q] <= ev_press_q[scan_q] & ~e_press;
            ev_hold_q[scan_q] <= ev_hold_q[scan_q] & ~e_hold;
            ev_rep_q[scan_q] <= ev_rep_q[scan_q] & ~e_rep;
            ev_rel_q[scan_q] <= ev_rel_q[scan_q] & ~e_rel;
            if (go) begin
                cmd_valid_q <= 1'b1;
                cmd_addr_q <= addr_b;
                cmd_data_q <= dbyte;
                if (addr_b[`SLCG_ADDR_SBIT] && sel == `SLCG_SEL_STEP)
                    step_q[scan_q] <= (step_q[scan_q] >= scene) ? 4'h0 : step_q[scan_q] + 4'h1;
                if (addr_b[`SLCG_ADDR_SBIT] && (sel == `SLCG_SEL_ONOFF ||
                    (sel == `SLCG_SEL_DIM && e_rel))) begin
                    lamp_q[scan_q] <= ~lamp;
                    fresh_q[scan_q] <= 1'b1;
                end
                if (addr_b[`SLCG_ADDR_SBIT] && sel == `SLCG_SEL_DIM && e_hold) begin
                    dirup_q[scan_q] <= up_now;
                    fresh_q[scan_q] <= 1'b0;
                    if (up_now)
                        lamp_q[scan_q] <= 1'b1;
                end
            end
        end
        // event sets come last so a new event beats a same-cycle clear
        if (tick_q) begin
            for (i = 0; i < 16; i = i + 1) begin
                if (~switch_input_pin_n[i] != stable_q[i]) begin
                    deb_q[i] <= deb_q[i] + 5'h01;
                    if ({5'h00, deb_q[i]} + 10'd1 >= `SLCG_DEBOUNCE_MS) begin
                        deb_q[i] <= 5'h00;
                        stable_q[i] <= ~switch_input_pin_n[i];
                        hold_q[i] <= 10'h000;
                        if (~switch_input_pin_n[i]) begin
                            ev_press_q[i] <= 1'b1;
                            held_q[i] <= 1'b0;
                        end else
                            ev_rel_q[i] <= 1'b1;
                    end
                end else begin
                    deb_q[i] <= 5'h00;
                    if (stable_q[i]) begin
                        hold_q[i] <= hold_q[i] + 10'h001;
                        if (hold_q[i] + 10'h001 == `SLCG_HOLD_MS) begin
                            ev_hold_q[i] <= 1'b1;
                            held_q[i] <= 1'b1;
                        end
                        if (hold_q[i] + 10'h001 == `SLCG_HOLD_MS + `SLCG_REPEAT_MS) begin
                            ev_rep_q[i] <= 1'b1;
                            hold_q[i] <= `SLCG_HOLD_MS;
                        end
                    end
                end
            end
        end
    end
end
endmodule // slcg_switch_cmd_gen
`default_nettype wire

/* verification/slcg_props.sv */
`timescale 1ns/1ns
`default_nettype none
module slcg_props #(
    parameter TICK_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [15:0] switch_input_pin_n,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out_q,
    input wire logic        sda_oe_q,
    input wire logic        cmd_valid_q,
    input wire logic        cmd_ready,
    input wire logic [7:0]  cmd_addr_q,
    input wire logic [7:0]  cmd_data_q
);
    // ----------------------------------------
    // cycles since the switches last moved
    // ----------------------------------------
    localparam int LIM = 22 * TICK_CYCLES + 64;
    logic [15:0] sw_q;
    int          quiet_q;
    always @(posedge clk) begin
        sw_q <= switch_input_pin_n;
        if (srst || sw_q != switch_input_pin_n)
            quiet_q <= 0;
        else if (quiet_q < 100000)
            quiet_q <= quiet_q + 1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_SDA_OPEN_DRAIN: assert property (sda_out_q == 1'b0)
        else $error("sda output value not low");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_q) |-> !scl_in)
        else $error("sda enable moved while scl high");
    AST_OE_QUIET: assert property ($fell(scl_in) |=> ##1 $stable(sda_oe_q) [*4])
        else $error("sda enable moved late in scl low phase");
    AST_CMD_STABLE: assert property (cmd_valid_q && !cmd_ready |=>
        cmd_valid_q && $stable(cmd_addr_q) && $stable(cmd_data_q))
        else $error("command changed before acceptance");
    AST_CMD_CODE_SET: assert property ($rose(cmd_valid_q) && cmd_addr_q[0] |->
        (cmd_data_q inside {8'h00, 8'h01, 8'h02, 8'h05}) || cmd_data_q[7:4] == 4'h1)
        else $error("unexpected command code");
    AST_DIRECT_CLOSED: assert property ($rose(cmd_valid_q) && !cmd_addr_q[0] |->
        switch_input_pin_n != 16'hFFFF)
        else $error("direct power sent with no switch closed");
    AST_QUIET_NO_CMD: assert property ($rose(cmd_valid_q) |->
        switch_input_pin_n != 16'hFFFF || quiet_q < LIM)
        else $error("command with switches long quiet");
    AST_QUIET_AFTER_RESET: assert property ($fell(srst) |-> !cmd_valid_q [*8])
        else $error("command right after reset");
    cover property (cmd_valid_q && !cmd_ready);
    cover property ($rose(sda_oe_q));
    cover property ($rose(cmd_valid_q) && !cmd_addr_q[0]);
endmodule // slcg_props
bind slcg_switch_cmd_gen slcg_props #(.TICK_CYCLES(TICK_CYCLES)) slcg_props_inst (
    .clk, .srst, .switch_input_pin_n, .scl_in, .sda_in, .sda_out_q, .sda_oe_q,
    .cmd_valid_q, .cmd_ready, .cmd_addr_q, .cmd_data_q);
`default_nettype wire

/* verification/slcg_cmd_taker.sv */
`timescale 1ns/1ns
`default_nettype none
module slcg_cmd_taker (
    input wire logic  clk,
    input wire logic  srst,
    input wire logic  slow,
    input wire logic  cmd_valid_q,
    output logic      cmd_ready
);
    // ----------------------------------------
    // slow mode takes one command in eight cycles
    // ----------------------------------------
    logic [2:0] wait_q;
    always @(posedge clk) begin
        if (srst)
            wait_q <= 3'h0;
        else
            wait_q <= wait_q + 3'h1;
    end
    assign cmd_ready = !srst && (!slow || wait_q == 3'h7);
endmodule // slcg_cmd_taker
`default_nettype wire

/* verification/tb_switch_lighting_command_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_switch_lighting_command_gen;
    localparam int           Q     = 4;
    localparam logic [15:0]  MAKER = 16'h3C3C; // arbitrary value
    localparam logic [15:0]  PROD  = 16'h0042; // arbitrary value
    localparam logic [15:0]  VER   = 16'h2041;
    localparam logic [47:0]  IDENT = {MAKER, PROD, VER};
    localparam logic [255:0] CFG   = {64'h0300250694870102, 64'hFF01030507080B0D,
                                      64'h0004000000000000, 64'h0055000000000000};
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] sw_n = 16'hFFFF;
    logic        scl = 1'b1;
    logic        sda_h = 1'b1;
    logic        slow = 1'b0;
    logic [6:0]  dev = 7'h20;
    wire logic   sda_out_q, sda_oe_q, cmd_valid_q, cmd_ready;
    wire logic [7:0] cmd_addr_q, cmd_data_q;
    wire logic   sda_w = sda_h & ~sda_oe_q;
    int          failures = 0;
    int          check_count = 0;
    logic [15:0] q[$];
    logic [7:0]  rbuf[0:31];
    logic [7:0]  wbuf[0:31];
    always #50 clk = ~clk;
    slcg_switch_cmd_gen #(.TICK_CYCLES(10), .MAKER_CODE(MAKER), .PRODUCT_CODE(PROD),
        .VERSION_BCD(VER)) slcg_switch_cmd_gen_inst (.clk, .srst,
        .switch_input_pin_n(sw_n), .scl_in(scl), .sda_in(sda_w), .sda_out_q, .sda_oe_q,
        .cmd_valid_q, .cmd_ready, .cmd_addr_q, .cmd_data_q);
    slcg_cmd_taker slcg_cmd_taker_inst (.clk, .srst, .slow, .cmd_valid_q, .cmd_ready);
    always @(posedge clk) begin
        if (!srst && cmd_valid_q && cmd_ready)
            q.push_back({cmd_addr_q, cmd_data_q});
    end
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic i2c_bit(input logic b, output logic r);
        sda_h = b;
        idle(Q);
        scl = 1'b1;
        idle(Q);
        r = sda_w;
        idle(Q);
        scl = 1'b0;
        idle(Q);
    endtask
    task automatic i2c_byte(input logic [7:0] d, input logic ai, output logic [7:0] r,
                            output logic a);
        for (int i = 7; i >= 0; i--)
            i2c_bit(d[i], r[i]);
        i2c_bit(ai, a);
    endtask
    task automatic xfer(input logic [7:0] rg, input int n, input logic rd, input logic nack);
        logic [7:0] r;
        logic       a;
        for (int s = 0; s <= int'(rd); s++) begin
            sda_h = 1'b1;
            idle(Q);
            scl = 1'b1;
            idle(Q);
            sda_h = 1'b0;
            idle(Q);
            scl = 1'b0;
            idle(Q);
            i2c_byte({dev, s == 1}, 1'b1, r, a);
            check_byte("address ack", {7'h0, nack}, {7'h0, a});
            if (s == 0)
                i2c_byte(rg, 1'b1, r, a);
        end
        for (int i = 0; i < n; i++)
            if (rd)
                i2c_byte(8'hFF, i == n - 1, rbuf[i], a);
            else
                i2c_byte(wbuf[i], 1'b1, r, a);
        sda_h = 1'b0;
        idle(Q);
        scl = 1'b1;
        idle(Q);
        sda_h = 1'b1;
        idle(Q);
    endtask
    task automatic press(input int i, input int n);
        sw_n[i] = 1'b0;
        idle(n);
        sw_n[i] = 1'b1;
        idle(400);
    endtask
    task automatic expect_cmd(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] c;
        int          t;
        t = 0;
        while (q.size() == 0 && t < 2000) begin
            idle(1);
            t++;
        end
        c = 16'hXXXX;
        if (q.size() != 0)
            c = q.pop_front();
        check_byte("command address", a, c[15:8]);
        check_byte("command data", d, c[7:0]);
    endtask
    task automatic expect_none();
        check_byte("extra commands", 8'h00, 8'(q.size()));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_ident();
        xfer(8'hF0, 6, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++)
            check_byte("ident", IDENT[47 - 8 * i -: 8], rbuf[i]);
    endtask
    task automatic t_table();
        xfer(8'h08, 16, 1'b1, 1'b0);
        for (int i = 0; i < 16; i++)
            check_byte("factory", i < 8 ? 8'h00 : i == 8 ? 8'hFF : 8'((i - 9) * 2 + 1), rbuf[i]);
        for (int i = 0; i < 32; i++)
            wbuf[i] = CFG[255 - 8 * i -: 8];
        xfer(8'h08, 32, 1'b0, 1'b0);
        xfer(8'h08, 32, 1'b1, 1'b0);
        for (int i = 0; i < 32; i++)
            check_byte("table", wbuf[i], rbuf[i]);
    endtask
    task automatic t_switches();
        slow = 1'b1;
        press(0, 300);
        expect_cmd(8'hFF, 8'h05);
        press(0, 4600);
        expect_cmd(8'hFF, 8'h00);
        expect_none();
        slow = 1'b0;
        press(2, 300);
        expect_cmd(8'h01, 8'h05);
        press(3, 300);
        expect_cmd(8'h01, 8'h00);
        press(2, 4600);
        expect_cmd(8'h01, 8'h01);
        q.delete();
        press(3, 4600);
        expect_cmd(8'h01, 8'h02);
        q.delete();
        for (int k = 0; k < 4; k++) begin
            press(4, 300);
            expect_cmd(8'h03, {4'h1, k == 3 ? 4'h0 : 4'(k)});
        end
        press(8, 300);
        expect_cmd(8'h07, 8'h19);
        press(6, 600);
        expect_cmd(8'h05, 8'h05);
        expect_cmd(8'h05, 8'h00);
        press(10, 300);
        expect_cmd(8'h08, 8'h87);
        press(12, 4600);
        expect_cmd(8'h0B, 8'h05);
        expect_none();
        press(13, 300);
        expect_cmd(8'h0B, 8'h00);
        press(14, 300);
        expect_cmd(8'h0D, 8'h05);
        press(14, 4600);
        expect_cmd(8'h0D, 8'h02);
        q.delete();
        press(14, 4600);
        expect_cmd(8'h0D, 8'h01);
        q.delete();
    endtask
    task automatic t_setaddr();
        wbuf[0] = 8'h31;
        wbuf[1] = 8'hCE;
        xfer(8'hFE, 2, 1'b0, 1'b0);
        xfer(8'hF0, 1, 1'b1, 1'b1);
        dev = 7'h31;
        wbuf[0] = 8'h90;
        wbuf[1] = 8'h6F;
        xfer(8'hFE, 2, 1'b0, 1'b0);
        wbuf[0] = 8'h22;
        wbuf[1] = 8'h00;
        xfer(8'hFE, 2, 1'b0, 1'b0);
        xfer(8'hF0, 1, 1'b1, 1'b0);
        check_byte("ident after move", MAKER[15:8], rbuf[0]);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        idle(10);
        srst = 1'b0;
        idle(5);
        t_ident();
        t_table();
        t_switches();
        t_setaddr();
        wrap_up();
    end
    // run needs about 56k cycles
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule // tb_switch_lighting_command_gen
`default_nettype wire
